// [design/fsrp_defines.vh]
// Command codes, phase codes and timing counts of the flash command control.
`ifndef FSRP_DEFINES_VH
`define FSRP_DEFINES_VH

`define FSRP_CMD_NONE 8'h00
`define FSRP_CMD_WRSR 8'h01
`define FSRP_CMD_PP 8'h02
`define FSRP_CMD_QPP 8'h32
`define FSRP_CMD_WRDIS 8'h04
`define FSRP_CMD_RDSR0 8'h05
`define FSRP_CMD_RDSR1 8'h35
`define FSRP_CMD_WREN 8'h06
`define FSRP_CMD_SE 8'h20
`define FSRP_CMD_BE32 8'h52
`define FSRP_CMD_BE64 8'hd8
`define FSRP_CMD_CE1 8'hc7
`define FSRP_CMD_CE2 8'h60
`define FSRP_CMD_SEC_ERASE 8'h44
`define FSRP_CMD_SEC_PROG 8'h42
`define FSRP_CMD_SEC_READ 8'h48
`define FSRP_CMD_RST_EN 8'h66
`define FSRP_CMD_RST 8'h99
`define FSRP_CMD_WRAP_READ 8'h0c
`define FSRP_CMD_SET_PARAM 8'hc0
`define FSRP_CMD_SET_WRAP 8'h77
`define FSRP_CMD_SUSPEND 8'h75
`define FSRP_CMD_RESUME 8'h7a
`define FSRP_CMD_DPD 8'hb9
`define FSRP_CMD_RELEASE 8'hab

// Frame phases.
`define FSRP_PH_CMD 3'h0
`define FSRP_PH_ADDR 3'h1
`define FSRP_PH_DUMMY 3'h2
`define FSRP_PH_OUT 3'h3
`define FSRP_PH_IN 3'h4
`define FSRP_PH_IGN 3'h5

// Timer users.
`define FSRP_TK_NONE 2'h0
`define FSRP_TK_RST 2'h1
`define FSRP_TK_RES 2'h2
`define FSRP_TK_DP 2'h3

// Security register address fields.
`define FSRP_SEC_UPPER 8'h00
`define FSRP_SEC_SEL_MAX 4'h3
`define FSRP_SEC_GAP 2'h0

// Timing, in ns, and derived cycle counts at the core clock.
// All kept at 16 bits so that the derived counts fit their counters exactly.
`define FSRP_CLK_NS 16'h0032
`define FSRP_CLK_UP (`FSRP_CLK_NS - 16'h0001)
`define FSRP_TRST_NS 16'h7530
`define FSRP_RELEASE_RECOVERY_TIME_NS 16'h4e20
`define FSRP_TDP_NS 16'h0bb8
`define FSRP_TSUS_NS 16'h9c40
`define FSRP_TRST_CYC ((`FSRP_TRST_NS + `FSRP_CLK_UP) / `FSRP_CLK_NS)
`define FSRP_RELEASE_RECOVERY_TIME_CYC ((`FSRP_RELEASE_RECOVERY_TIME_NS + `FSRP_CLK_UP) / `FSRP_CLK_NS)
`define FSRP_TDP_CYC ((`FSRP_TDP_NS + `FSRP_CLK_UP) / `FSRP_CLK_NS)
`define FSRP_TSUS_CYC (`FSRP_TSUS_NS / `FSRP_CLK_NS)

// Arbitrary device identification value.
`define FSRP_DEVICE_ID 8'h5a

`endif

// [design/fsrp_secmem.v]
// Security register storage, three banks of 1024 bytes, registered read.
`timescale 1ns/100ps
`default_nettype none
module fsrp_secmem (
  input wire clk, // Core clock.
  input wire wr_en, // Write strobe.
  input wire [11:0] wr_addr, // Write address, bank and byte.
  input wire [7:0] wr_data, // Write data.
  input wire [11:0] rd_addr, // Read address, bank and byte.
  output reg [7:0] rd_data // Read data, one cycle after the address.
);
  reg [7:0] mem [0:3071];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [design/fsrp_ctl.v]
// Serial flash command control: reset, suspend, power-down, special reads.
//
// Summary of operation
// - Security read address wraps within low ten bits.
// - Security bank chosen by address bits 15-12.
// - Software reset clears all volatile state.
// - Reset needs enable frame then reset frame.
// - Commands refused during reset recovery.
// - Quad wrapped read wraps in configured window.
// - Suspend accepted only during running program/erase.
// - Suspend sets flag, clears busy within latency.
// - Program suspend refuses all write commands.
// - Erase suspend refuses status write and erases.
// - Resume clears suspend flag, sets busy quickly.
// - Power-down only by command; few commands pass.
// - Deselect when idle gives standby mode.
// - Power-down needs exactly eight bits, then delay.
// - Power-down rejected while a cycle runs.
// - Power-up always starts in standby.
// - Commands refused during release recovery.
// - ID read: three dummy bytes, ID out MSB first.
// - Three address bytes, dummy, rise in, fall out.
// - Release command ignored while busy.
`timescale 1ns/100ps
`default_nettype none
`include "fsrp_defines.vh"
module fsrp_ctl (
  input wire core_clk, // Core clock, 20 MHz.
  input wire rst_n, // Power-up reset, active low.
  input wire cs_n_pin, // Chip select pin, active low.
  input wire sclk_pin, // Serial clock pin.
  input wire [3:0] io_in, // Data pins, input side.
  output reg [3:0] io_out, // Data pins, output side.
  output reg [3:0] io_oe, // Data pins, output enables.
  input wire qpi_mode, // Quad peripheral mode selected.
  output reg eng_start, // Start pulse to the array engine.
  output reg [7:0] eng_cmd, // Command for the array engine.
  output reg [23:0] eng_addr, // Address for the array engine.
  output reg eng_suspend, // Suspend pulse to the array engine.
  output reg eng_resume, // Resume pulse to the array engine.
  output reg eng_abort, // Abort pulse on software reset.
  input wire eng_done, // Array engine finished its operation.
  input wire eng_halted, // Array engine has paused.
  output reg [23:0] arr_rd_addr, // Array read address.
  input wire [7:0] arr_rd_data, // Array read data.
  input wire sec_wr_en, // Security storage write strobe.
  input wire [11:0] sec_wr_addr, // Security storage write address.
  input wire [7:0] sec_wr_data, // Security storage write data.
  output reg write_in_progress_flag, // Internal cycle busy.
  output reg write_enable_latch, // Writes enabled.
  output reg [1:0] suspend_status_flags, // Bit 0 program, bit 1 erase.
  output reg deep_power_down, // Deep power-down mode.
  output reg standby, // Deselected and idle.
  output reg [7:0] read_parameter_bits, // Read parameters.
  output reg [2:0] wrap_setting_bits, // Wrap setting.
  output reg [7:0] continuous_read_mode_bits // Continuous read mode.
);
  localparam [15:0] TRST_CYC = `FSRP_TRST_CYC;
  localparam [15:0] RELEASE_RECOVERY_TIME_CYC = `FSRP_RELEASE_RECOVERY_TIME_CYC;
  localparam [15:0] TDP_CYC = `FSRP_TDP_CYC;
  localparam [15:0] TSUS_CYC = `FSRP_TSUS_CYC;

  reg [5:0] sync1;
  reg [5:0] sync2;
  reg sclk_d;
  reg cs_d;
  reg [2:0] phase;
  reg [7:0] cmd;
  reg [7:0] in_sh;
  reg [3:0] bit_cnt;
  reg [2:0] nbytes;
  reg [23:0] addr;
  reg [3:0] dummy_left;
  reg [7:0] out_sh;
  reg [3:0] out_cnt;
  reg rst_armed;
  reg [1:0] tmr_kind;
  reg [15:0] tmr;
  reg sus_wait;
  reg [15:0] sus_tmr;
  reg op_sus_ok;
  reg op_erase;
  wire [7:0] sec_rd_data;

  wire cs_hi = sync2[5];
  wire sclk_s = sync2[4];
  wire [3:0] io_s = sync2[3:0];
  wire rise = ~cs_hi & sclk_s & ~sclk_d;
  wire fall = ~cs_hi & ~sclk_s & sclk_d;
  wire cs_rise = cs_hi & ~cs_d;
  wire cs_fall = ~cs_hi & cs_d;
  wire [3:0] step = qpi_mode ? 4'h4 : 4'h1;
  wire [3:0] next_bit_cnt = bit_cnt + step;
  wire byte_done = next_bit_cnt[3];
  wire [7:0] next_in_sh = qpi_mode ? {in_sh[3:0], io_s} :
                                     {in_sh[6:0], io_s[0]};
  wire exact8 = (nbytes == 3'h1) && (bit_cnt == 4'h0);
  wire [1:0] sec_bank = addr[13:12] - 2'h1;
  wire sec_ok = (addr[23:16] == `FSRP_SEC_UPPER) &&
                (addr[15:12] != 4'h0) &&
                (addr[15:12] <= `FSRP_SEC_SEL_MAX) &&
                (addr[11:10] == `FSRP_SEC_GAP);
  wire [7:0] wrap_mask = (8'h08 << read_parameter_bits[1:0]) - 8'h01;
  wire [3:0] param_dummy = {1'b0, read_parameter_bits[5:4], 1'b0} + 4'h2;
  wire [7:0] status0 = {6'h00, write_enable_latch, write_in_progress_flag};
  wire [7:0] status1 = {suspend_status_flags[0], 4'h0,
                        suspend_status_flags[1], 2'h0};
  reg [7:0] out_src;

  function is_prog;
    input [7:0] c;
    begin
      is_prog = (c == `FSRP_CMD_PP) || (c == `FSRP_CMD_QPP) ||
                (c == `FSRP_CMD_SEC_PROG);
    end
  endfunction

  function is_erase;
    input [7:0] c;
    begin
      is_erase = (c == `FSRP_CMD_SE) || (c == `FSRP_CMD_BE32) ||
                 (c == `FSRP_CMD_BE64) || (c == `FSRP_CMD_CE1) ||
                 (c == `FSRP_CMD_CE2) || (c == `FSRP_CMD_SEC_ERASE);
    end
  endfunction

  function is_write;
    input [7:0] c;
    begin
      is_write = is_prog(c) || is_erase(c) || (c == `FSRP_CMD_WRSR);
    end
  endfunction

  function has_addr;
    input [7:0] c;
    begin
      has_addr = is_prog(c) || (is_erase(c) && (c != `FSRP_CMD_CE1) &&
                 (c != `FSRP_CMD_CE2)) || (c == `FSRP_CMD_SEC_READ) ||
                 (c == `FSRP_CMD_WRAP_READ) || (c == `FSRP_CMD_RELEASE);
    end
  endfunction

  // Program suspend blocks every write; erase suspend blocks erases and status write.
  wire refused = suspend_status_flags[0] ? is_write(cmd) :
                 suspend_status_flags[1] ?
                 (is_erase(cmd) || (cmd == `FSRP_CMD_WRSR)) :
                 1'b0;

  wire cmd_ok = (tmr_kind == `FSRP_TK_NONE) &&
                (!deep_power_down || (next_in_sh == `FSRP_CMD_RELEASE) ||
                 (next_in_sh == `FSRP_CMD_RST_EN) ||
                 (next_in_sh == `FSRP_CMD_RST)) &&
                !((next_in_sh == `FSRP_CMD_RELEASE) &&
                  write_in_progress_flag) &&
                !(((next_in_sh == `FSRP_CMD_WRAP_READ) ||
                   (next_in_sh == `FSRP_CMD_SET_PARAM)) && !qpi_mode);

  always @* begin
    case (cmd)
      `FSRP_CMD_RDSR0: out_src = status0;
      `FSRP_CMD_RDSR1: out_src = status1;
      `FSRP_CMD_RELEASE: out_src = `FSRP_DEVICE_ID;
      `FSRP_CMD_SEC_READ: out_src = sec_ok ? sec_rd_data : 8'hff;
      `FSRP_CMD_WRAP_READ: out_src = arr_rd_data;
      default: out_src = 8'hff;
    endcase
  end

  fsrp_secmem u_secmem (
    .clk(core_clk),
    .wr_en(sec_wr_en),
    .wr_addr(sec_wr_addr),
    .wr_data(sec_wr_data),
    .rd_addr({sec_bank, addr[9:0]}),
    .rd_data(sec_rd_data)
  );

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 6'h20;
      sync2 <= 6'h20;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      phase <= `FSRP_PH_IGN;
      cmd <= `FSRP_CMD_NONE;
      in_sh <= 8'h00;
      bit_cnt <= 4'h0;
      nbytes <= 3'h0;
      addr <= 24'h000000;
      dummy_left <= 4'h0;
      out_sh <= 8'h00;
      out_cnt <= 4'h0;
      io_out <= 4'h0;
      io_oe <= 4'h0;
      rst_armed <= 1'b0;
      tmr_kind <= `FSRP_TK_NONE;
      tmr <= 16'h0000;
      sus_wait <= 1'b0;
      sus_tmr <= 16'h0000;
      op_sus_ok <= 1'b0;
      op_erase <= 1'b0;
      eng_start <= 1'b0;
      eng_cmd <= 8'h00;
      eng_addr <= 24'h000000;
      eng_suspend <= 1'b0;
      eng_resume <= 1'b0;
      eng_abort <= 1'b0;
      arr_rd_addr <= 24'h000000;
      write_in_progress_flag <= 1'b0;
      write_enable_latch <= 1'b0;
      suspend_status_flags <= 2'h0;
      deep_power_down <= 1'b0;
      standby <= 1'b0;
      read_parameter_bits <= 8'h00;
      wrap_setting_bits <= 3'h0;
      continuous_read_mode_bits <= 8'h00;
    end else begin
      sync1 <= {cs_n_pin, sclk_pin, io_in};
      sync2 <= sync1;
      sclk_d <= sclk_s;
      cs_d <= cs_hi;
      eng_start <= 1'b0;
      eng_suspend <= 1'b0;
      eng_resume <= 1'b0;
      eng_abort <= 1'b0;
      arr_rd_addr <= addr;
      standby <= cs_hi && !write_in_progress_flag &&
                 !deep_power_down;

      // Recovery and entry delays.
      if (tmr_kind != `FSRP_TK_NONE) begin
        if (tmr == 16'h0000) begin
          if (tmr_kind == `FSRP_TK_RES) begin
            deep_power_down <= 1'b0;
          end
          if (tmr_kind == `FSRP_TK_DP) begin
            deep_power_down <= 1'b1;
          end
          tmr_kind <= `FSRP_TK_NONE;
        end else begin
          tmr <= tmr - 16'h0001;
        end
      end

      if (eng_done) begin
        write_in_progress_flag <= 1'b0;
        write_enable_latch <= 1'b0;
      end

      // Busy drops when the engine pauses, or at the latency limit.
      if (sus_wait) begin
        if (eng_halted || (sus_tmr == 16'h0000)) begin
          write_in_progress_flag <= 1'b0;
          sus_wait <= 1'b0;
        end else begin
          sus_tmr <= sus_tmr - 16'h0001;
        end
      end

      if (cs_hi) begin
        io_oe <= 4'h0;
      end

      if (cs_fall) begin
        phase <= `FSRP_PH_CMD;
        cmd <= `FSRP_CMD_NONE;
        bit_cnt <= 4'h0;
        nbytes <= 3'h0;
        out_cnt <= 4'h0;
      end else if (rise && (phase != `FSRP_PH_OUT) &&
                   (phase != `FSRP_PH_IGN)) begin
        in_sh <= next_in_sh;
        if (phase == `FSRP_PH_DUMMY) begin
          dummy_left <= dummy_left - 4'h1;
          if (dummy_left == 4'h1) begin
            phase <= `FSRP_PH_OUT;
          end
        end else begin
          bit_cnt <= byte_done ? 4'h0 : next_bit_cnt;
        end
        if (byte_done && (phase != `FSRP_PH_DUMMY)) begin
          if (nbytes != 3'h7) begin
            nbytes <= nbytes + 3'h1;
          end
          case (phase)
            `FSRP_PH_CMD: begin
              if (!cmd_ok) begin
                phase <= `FSRP_PH_IGN;
              end else begin
                cmd <= next_in_sh;
                if ((next_in_sh == `FSRP_CMD_RDSR0) ||
                    (next_in_sh == `FSRP_CMD_RDSR1)) begin
                  phase <= `FSRP_PH_OUT;
                end else if (has_addr(next_in_sh) &&
                             !deep_power_down) begin
                  phase <= `FSRP_PH_ADDR;
                end else begin
                  phase <= `FSRP_PH_IN;
                end
              end
            end
            `FSRP_PH_ADDR: begin
              addr <= {addr[15:0], next_in_sh};
              if (nbytes == 3'h3) begin
                if (cmd == `FSRP_CMD_SEC_READ) begin
                  phase <= `FSRP_PH_DUMMY;
                  dummy_left <= qpi_mode ? 4'h2 : 4'h8;
                end else if (cmd == `FSRP_CMD_WRAP_READ) begin
                  phase <= `FSRP_PH_DUMMY;
                  dummy_left <= param_dummy;
                end else if (cmd == `FSRP_CMD_RELEASE) begin
                  phase <= `FSRP_PH_OUT;
                end else begin
                  phase <= `FSRP_PH_IN;
                end
              end
            end
            `FSRP_PH_IN: begin
              if ((cmd == `FSRP_CMD_SET_PARAM) && (nbytes == 3'h1)) begin
                read_parameter_bits <= next_in_sh;
              end
              if ((cmd == `FSRP_CMD_SET_WRAP) && (nbytes == 3'h3)) begin
                wrap_setting_bits <= next_in_sh[6:4];
              end
            end
            default: begin
              phase <= phase;
            end
          endcase
        end
      end

      // Output bits change on falling serial clock edges.
      if (fall && (phase == `FSRP_PH_OUT)) begin
        io_oe <= qpi_mode ? 4'hf : 4'h2;
        if (out_cnt == 4'h0) begin
          io_out <= qpi_mode ? out_src[7:4] : {2'h0, out_src[7], 1'b0};
          out_sh <= qpi_mode ? {out_src[3:0], 4'h0} :
                               {out_src[6:0], 1'b0};
          out_cnt <= 4'h8 - step;
          if (cmd == `FSRP_CMD_SEC_READ) begin
            addr <= {addr[23:10], addr[9:0] + 10'h001};
          end
          if (cmd == `FSRP_CMD_WRAP_READ) begin
            addr <= {addr[23:8], (addr[7:0] & ~wrap_mask) |
                     ((addr[7:0] + 8'h01) & wrap_mask)};
          end
        end else begin
          io_out <= qpi_mode ? out_sh[7:4] : {2'h0, out_sh[7], 1'b0};
          out_sh <= qpi_mode ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'b0};
          out_cnt <= out_cnt - step;
        end
      end

      // Commands take effect when chip select rises.
      if (cs_rise && (phase != `FSRP_PH_IGN)) begin
        rst_armed <= (cmd == `FSRP_CMD_RST_EN) && exact8;
        case (cmd)
          `FSRP_CMD_RST: begin
            if (rst_armed && exact8) begin
              eng_abort <= 1'b1;
              write_in_progress_flag <= 1'b0;
              write_enable_latch <= 1'b0;
              suspend_status_flags <= 2'h0;
              read_parameter_bits <= 8'h00;
              deep_power_down <= 1'b0;
              continuous_read_mode_bits <= 8'h00;
              wrap_setting_bits <= 3'h0;
              sus_wait <= 1'b0;
              op_sus_ok <= 1'b0;
              tmr_kind <= `FSRP_TK_RST;
              tmr <= TRST_CYC;
            end
          end
          `FSRP_CMD_WREN: begin
            if (exact8) begin
              write_enable_latch <= 1'b1;
            end
          end
          `FSRP_CMD_WRDIS: begin
            if (exact8) begin
              write_enable_latch <= 1'b0;
            end
          end
          `FSRP_CMD_SUSPEND: begin
            if (exact8 && write_in_progress_flag && op_sus_ok &&
                (suspend_status_flags == 2'h0) && !sus_wait) begin
              suspend_status_flags <= op_erase ? 2'h2 : 2'h1;
              eng_suspend <= 1'b1;
              sus_wait <= 1'b1;
              sus_tmr <= TSUS_CYC;
            end
          end
          `FSRP_CMD_RESUME: begin
            if (exact8 && (suspend_status_flags != 2'h0) &&
                !write_in_progress_flag) begin
              suspend_status_flags <= 2'h0;
              write_in_progress_flag <= 1'b1;
              eng_resume <= 1'b1;
            end
          end
          `FSRP_CMD_DPD: begin
            if (exact8 && !write_in_progress_flag) begin
              tmr_kind <= `FSRP_TK_DP;
              tmr <= TDP_CYC;
            end
          end
          `FSRP_CMD_RELEASE: begin
            if (deep_power_down) begin
              tmr_kind <= `FSRP_TK_RES;
              tmr <= RELEASE_RECOVERY_TIME_CYC;
            end
          end
          default: begin
            if (is_write(cmd) && write_enable_latch && !refused &&
                !write_in_progress_flag && (bit_cnt == 4'h0)) begin
              eng_start <= 1'b1;
              eng_cmd <= cmd;
              eng_addr <= addr;
              write_in_progress_flag <= 1'b1;
              op_sus_ok <= (suspend_status_flags == 2'h0) &&
                           (cmd != `FSRP_CMD_WRSR) &&
                           (cmd != `FSRP_CMD_SEC_PROG) &&
                           (cmd != `FSRP_CMD_SEC_ERASE) &&
                           (cmd != `FSRP_CMD_CE1) &&
                           (cmd != `FSRP_CMD_CE2);
              if (suspend_status_flags == 2'h0) begin
                op_erase <= is_erase(cmd);
              end
            end
          end
        endcase
      end else if (cs_rise) begin
        rst_armed <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/fsrp_host.sv]
// Host controller model that drives the serial flash pins.
`timescale 1ns/100ps
`default_nettype none
module fsrp_host (
  input wire logic clk, // Core clock used for pacing.
  input wire logic quad_peripheral_mode, // Quad peripheral mode.
  input wire logic [3:0] dq_in, // Resolved data pin levels.
  output logic cs_n, // Chip select, active low.
  output logic sclk, // Serial clock, still between frames.
  output logic [3:0] dq // Data driven towards the device.
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    dq = 4'h0;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start_f();
    cs_n = 1'b0;
    hc(4);
  endtask
  // Released lines show the inverse so stale data never looks valid.
  task automatic end_f(input int gap);
    hc(4);
    cs_n = 1'b1;
    dq = ~dq;
    hc(gap);
  endtask
  // Bits leave MSB first, change while sclk is low, sampled before rise.
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    int i, w;
    w = quad_peripheral_mode ? 4 : 1;
    r = 8'h00;
    for (i = 8 - w; i >= 0; i = i - w) begin
      dq = 4'(b >> i);
      hc(4);
      r = (r << w) | (quad_peripheral_mode ? 8'(dq_in) : 8'(dq_in[1]));
      sclk = 1'b1;
      hc(4);
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb/fsrp_ctl_sva.sv]
// Assertion checker on the flash command control ports.
`timescale 1ns/100ps
`default_nettype none
module fsrp_ctl_sva (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic [3:0] io_oe, // Output enables.
  input wire logic eng_start, // Engine start.
  input wire logic eng_suspend, // Engine suspend.
  input wire logic eng_resume, // Engine resume.
  input wire logic eng_abort, // Engine abort.
  input wire logic write_in_progress_flag, // Busy.
  input wire logic write_enable_latch, // Write enable.
  input wire logic [1:0] suspend_status_flags, // Suspend flags.
  input wire logic deep_power_down // Power-down state.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_abort;
    eng_abort |-> ##[0:1] (suspend_status_flags == 2'h0 &&
      !write_enable_latch && !deep_power_down);
  endproperty
  a_abort: assert property (p_abort) else $error("abort kept state");
  property p_sus_ok;
    eng_suspend |-> $past(write_in_progress_flag) &&
      $past(suspend_status_flags) == 2'h0;
  endproperty
  a_sus_ok: assert property (p_sus_ok) else $error("bad suspend");
  property p_sus_flag;
    $rose(|suspend_status_flags) |-> eng_suspend;
  endproperty
  a_sus_flag: assert property (p_sus_flag) else $error("flag rose");
  property p_sus_wip;
    eng_suspend |=> ##[0:800] !write_in_progress_flag;
  endproperty
  a_sus_wip: assert property (p_sus_wip) else $error("busy stuck");
  property p_res_ok;
    eng_resume |-> $past(suspend_status_flags) != 2'h0 &&
      !$past(write_in_progress_flag);
  endproperty
  a_res_ok: assert property (p_res_ok) else $error("bad resume");
  property p_res_eff;
    eng_resume |-> suspend_status_flags == 2'h0 && write_in_progress_flag;
  endproperty
  a_res_eff: assert property (p_res_eff) else $error("resume");
  property p_one_flag;
    $onehot0(suspend_status_flags);
  endproperty
  a_one_flag: assert property (p_one_flag) else $error("two flags");
  property p_dpd_idle;
    $rose(deep_power_down) |-> !write_in_progress_flag;
  endproperty
  a_dpd_idle: assert property (p_dpd_idle) else $error("dpd busy");
  property p_dpd_start;
    deep_power_down |-> !eng_start;
  endproperty
  a_dpd_start: assert property (p_dpd_start) else $error("dpd op");
  property p_oe;
    io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hf;
  endproperty
  a_oe: assert property (p_oe) else $error("odd output enable");
endmodule
bind fsrp_ctl fsrp_ctl_sva u_sva (.core_clk, .rst_n, .io_oe, .eng_start,
  .eng_suspend, .eng_resume, .eng_abort, .write_in_progress_flag,
  .write_enable_latch, .suspend_status_flags, .deep_power_down);
`default_nettype wire

// [tb/fsrp_ctl_tb.sv]
// Self-checking testbench of the flash command control.
`timescale 1ns/100ps
`default_nettype none
`include "fsrp_defines.vh"
module fsrp_ctl_tb;
  logic core_clk, rst_n, qpi_mode, eng_done, eng_halted, sec_wr_en;
  logic [11:0] sec_wr_addr;
  logic [7:0] sec_wr_data, r;
  logic cs_n, sclk, eng_start, eng_suspend, eng_resume, eng_abort;
  logic [3:0] dq, io_out, io_oe;
  logic write_in_progress_flag, write_enable_latch, deep_power_down, standby;
  logic [1:0] suspend_status_flags;
  logic [23:0] eng_addr, arr_rd_addr;
  logic [7:0] eng_cmd, read_parameter_bits, continuous_read_mode_bits;
  logic [2:0] wrap_setting_bits;
  // Array model: every byte reads back the low byte of its own address.
  wire logic [7:0] arr_rd_data = arr_rd_addr[7:0];
  int error_cnt = 0, n_checks = 0;
  wire logic [3:0] pin = (io_oe & io_out) | (~io_oe & dq);
  fsrp_host h (.clk(core_clk), .quad_peripheral_mode(qpi_mode), .dq_in(pin), .cs_n(cs_n),
    .sclk(sclk), .dq(dq));
  fsrp_ctl uut (.core_clk, .rst_n, .cs_n_pin(cs_n), .sclk_pin(sclk),
    .io_in(pin), .io_out, .io_oe, .qpi_mode, .eng_start, .eng_cmd,
    .eng_addr, .eng_suspend, .eng_resume, .eng_abort, .eng_done,
    .eng_halted, .arr_rd_addr, .arr_rd_data, .sec_wr_en,
    .sec_wr_addr, .sec_wr_data, .write_in_progress_flag,
    .write_enable_latch, .suspend_status_flags, .deep_power_down,
    .standby, .read_parameter_bits, .wrap_setting_bits,
    .continuous_read_mode_bits);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sends the top n bytes of w; a zero gap leaves the frame open.
  task automatic go(input logic [39:0] w, input int n, input int gap);
    int i;
    h.start_f();
    for (i = 0; i < n; i++) h.xfer(w[39-8*i -: 8], r);
    if (gap > 0) h.end_f(gap);
  endtask
  task automatic t_power();
    h.hc(8);
    chk(standby, 8'h01);
    chk(deep_power_down, 8'h00);
  endtask
  task automatic t_id();
    go(40'hab_0000_0000, 4, 0);
    h.xfer(8'h00, r);
    h.end_f(8);
    chk(r, `FSRP_DEVICE_ID);
  endtask
  task automatic t_sec();
    sec_wr_en = 1'b1;
    sec_wr_addr = 12'h3ff;
    sec_wr_data = 8'hc3;
    h.hc(1);
    sec_wr_addr = 12'h000;
    sec_wr_data = 8'h3c;
    h.hc(1);
    sec_wr_en = 1'b0;
    go(40'h48_0013ff_00, 5, 0);
    h.xfer(8'h00, r);
    chk(r, 8'hc3);
    h.xfer(8'h00, r);
    chk(r, 8'h3c);
    h.end_f(8);
  endtask
  task automatic t_susp();
    go(40'h06_0000_0000, 1, 8);
    go(40'h02_000100_a5, 5, 8);
    chk(write_in_progress_flag, 8'h01);
    chk(eng_cmd, 8'h02);
    chk(eng_addr[15:8], 8'h01);
    chk(standby, 8'h00);
    go(40'hab_0000_0000, 4, 0);
    h.xfer(8'h00, r);
    h.end_f(8);
    chk(r, 8'h00);
    go(40'hb9_0000_0000, 1, 70);
    chk(deep_power_down, 8'h00);
    go(40'h75_0000_0000, 1, 8);
    chk(suspend_status_flags, 8'h01);
    eng_halted = 1'b1;
    h.hc(3);
    chk(write_in_progress_flag, 8'h00);
    go(40'h75_0000_0000, 1, 8);
    chk(suspend_status_flags, 8'h01);
    go(40'h35_0000_0000, 1, 0);
    h.xfer(8'h00, r);
    h.end_f(8);
    chk(r, 8'h80);
    go(40'h06_0000_0000, 1, 8);
    go(40'h20_001000_00, 4, 8);
    chk(write_in_progress_flag, 8'h00);
    eng_halted = 1'b0;
    go(40'h7a_0000_0000, 1, 8);
    chk(suspend_status_flags, 8'h00);
    chk(write_in_progress_flag, 8'h01);
    eng_done = 1'b1;
    h.hc(1);
    eng_done = 1'b0;
    h.hc(2);
    chk(write_in_progress_flag, 8'h00);
  endtask
  task automatic t_rst();
    chk(write_in_progress_flag, 8'h00);
    chk(suspend_status_flags, 8'h00);
    qpi_mode = 1'b1;
    go(40'hc0_10_000000, 2, 8);
    chk(read_parameter_bits, 8'h10);
    go(40'h77_000040_00, 4, 8);
    chk(wrap_setting_bits, 8'h04);
    go(40'h0c_000106_00, 5, 0);
    h.xfer(8'h00, r);
    h.xfer(8'h00, r);
    chk(r, 8'h06);
    h.xfer(8'h00, r);
    chk(r, 8'h07);
    h.xfer(8'h00, r);
    chk(r, 8'h00);
    h.end_f(8);
    go(40'h06_0000_0000, 1, 8);
    chk(write_enable_latch, 8'h01);
    go(40'h66_0000_0000, 1, 8);
    go(40'h99_0000_0000, 1, 8);
    chk(write_enable_latch, 8'h00);
    chk(read_parameter_bits, 8'h00);
    chk(wrap_setting_bits, 8'h00);
    chk(continuous_read_mode_bits, 8'h00);
    go(40'h06_0000_0000, 1, 8);
    chk(write_enable_latch, 8'h00);
    h.hc(620);
    qpi_mode = 1'b0;
  endtask
  task automatic t_dpd();
    go(40'hb9_0000_0000, 1, 70);
    chk(deep_power_down, 8'h01);
    go(40'h06_0000_0000, 1, 8);
    chk(write_enable_latch, 8'h00);
    go(40'hab_0000_0000, 1, 410);
    chk(deep_power_down, 8'h00);
    go(40'h06_0000_0000, 1, 8);
    chk(write_enable_latch, 8'h01);
    go(40'hb9_0000_0000, 1, 70);
    chk(deep_power_down, 8'h01);
    rst_n = 1'b0;
    h.hc(4);
    rst_n = 1'b1;
    h.hc(8);
    chk(deep_power_down, 8'h00);
    chk(standby, 8'h01);
  endtask
  initial begin
    rst_n = 1'b0;
    qpi_mode = 1'b0;
    eng_done = 1'b0;
    eng_halted = 1'b0;
    sec_wr_en = 1'b0;
    sec_wr_addr = 12'h000;
    sec_wr_data = 8'h00;
    h.hc(4);
    rst_n = 1'b1;
    t_power();
    t_id();
    t_sec();
    t_susp();
    t_rst();
    t_dpd();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
